// *** rtl/crs_seq.sv ***
`timescale 1ns/10ps
module crs_seq import crs_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input crs_cmd_t cmd,
	input wire logic [7:0] mem_rdata,
	output crs_mem_t mem,
	output crs_res_t res
);
	crs_state_t s_q;
	crs_state_t s_d;
	logic [AW-1:0] ret_addr;
	logic [AW-1:0] target;
	logic [CW-1:0] base_clk;
	logic [SW-1:0] ofs;
	logic [1:0] widx;
	logic is_pop;

	crs_target u_target (
		.cmd(cmd),
		.ret_addr(ret_addr),
		.target(target)
	);

	function automatic logic [7:0] ret_byte(input logic [AW-1:0] r, input logic [1:0] k);
		case (k)
			TAG_LOW: ret_byte = {4'h0, r[19:16]};
			TAG_MID: ret_byte = r[15:8];
			default: ret_byte = r[7:0];
		endcase
	endfunction : ret_byte

	always_comb begin
		case (cmd.op)
			OP_CALL_REG, OP_CALL_REL, OP_CALL_ABS16, OP_CALL_ABS20: base_clk = CLK_CALL;
			OP_TBL: base_clk = CLK_TBL;
			OP_BRK: base_clk = CLK_BRK;
			OP_RET: base_clk = CLK_RET;
			default: base_clk = CLK_INTERRUPT_EXIT;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.mem = '0;
		s_d.res.done = 1'b0;
		s_d.rd_pend = 1'b0;
		// data shows on the pins the cycle after the request leaves the port
		s_d.rd_due = s_q.rd_pend;
		s_d.due_tag = s_q.rd_tag;
		ofs = '0;
		widx = '0;
		// synchronous memory: read byte is valid one cycle after the request
		if (s_q.rd_due) begin
			case (s_q.due_tag)
				TAG_LOW: s_d.pc[7:0] = mem_rdata;
				TAG_MID: s_d.pc[15:8] = mem_rdata;
				TAG_TOP: s_d.pc[19:16] = mem_rdata[3:0];
				default: s_d.program_status_word = mem_rdata;
			endcase
		end
		is_pop = (s_q.op == OP_RET) || (s_q.op == OP_INTERRUPT_EXIT) || (s_q.op == OP_BREAK_EXIT);
		case (s_q.st)
			ST_IDLE: begin
				if (start) begin
					s_d.st = ST_RUN;
					s_d.op = cmd.op;
					s_d.cnt = STEP0;
					s_d.lim = base_clk;
					if (cmd.ram_fetch) begin
						s_d.lim = (base_clk << RAM_SHIFT) + RAM_ADD;
					end
					s_d.ret = ret_addr;
					s_d.pc = target;
					s_d.sp = cmd.sp;
					s_d.program_status_word = cmd.program_status_word;
					s_d.tidx = cmd.tidx;
					s_d.res.busy = 1'b1;
				end
			end
			default: begin
				s_d.cnt = s_q.cnt + STEP1;
				if (s_q.cnt == s_q.lim - STEP1) begin
					s_d.st = ST_IDLE;
					s_d.res.busy = 1'b0;
					s_d.res.done = 1'b1;
					s_d.res.pc = s_d.pc;
					if (is_pop) begin
						s_d.res.sp = s_q.sp + SP_ADJ;
					end else begin
						s_d.res.sp = s_q.sp - SP_ADJ;
					end
					s_d.res.program_status_word = s_d.program_status_word;
					if (s_q.op == OP_BRK) begin
						s_d.res.program_status_word[IE_BIT] = 1'b0;
					end
				end
			end
		endcase
		// access for the coming cycle, so the port comes straight from flops
		if (s_d.st == ST_RUN) begin
			case (s_d.op)
				OP_BRK: begin
					if (s_d.cnt == STEP0) begin
						s_d.mem = '{req: 1'b1, we: 1'b1, addr: {STACK_BANK, s_d.sp - OFS_PSW}, wdata: s_d.program_status_word};
					end else if (s_d.cnt <= STEP3) begin
						ofs = SW'(s_d.cnt) + OFS_PSW;
						widx = 2'(s_d.cnt - STEP1);
						s_d.mem = '{req: 1'b1, we: 1'b1, addr: {STACK_BANK, s_d.sp - ofs},
							wdata: ret_byte(s_d.ret, widx)};
					end else if (s_d.cnt == STEP4) begin
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: VEC_LOW, wdata: 8'h00};
						s_d.rd_tag = TAG_LOW;
					end else if (s_d.cnt == STEP5) begin
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: VEC_HIGH, wdata: 8'h00};
						s_d.rd_tag = TAG_MID;
					end
				end
				OP_RET, OP_INTERRUPT_EXIT, OP_BREAK_EXIT: begin
					if (s_d.cnt <= STEP2) begin
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: {STACK_BANK, s_d.sp + SW'(s_d.cnt)}, wdata: 8'h00};
						s_d.rd_tag = 2'(s_d.cnt);
					end else if (s_d.cnt == STEP3 && s_d.op != OP_RET) begin
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: {STACK_BANK, s_d.sp + POP_PSW}, wdata: 8'h00};
						s_d.rd_tag = TAG_PSW;
					end
				end
				default: begin
					if (s_d.cnt <= STEP2) begin
						ofs = SW'(s_d.cnt) + OFS_TOP;
						widx = 2'(s_d.cnt);
						s_d.mem = '{req: 1'b1, we: 1'b1, addr: {STACK_BANK, s_d.sp - ofs},
							wdata: ret_byte(s_d.ret, widx)};
					end else if (s_d.op == OP_TBL && s_d.cnt == STEP3) begin
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: {LOW_BANK, s_d.tidx}, wdata: 8'h00};
						s_d.rd_tag = TAG_LOW;
					end else if (s_d.op == OP_TBL && s_d.cnt == STEP4) begin
						// middle byte from index plus one
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: {LOW_BANK, s_d.tidx + TBL_NEXT}, wdata: 8'h00};
						s_d.rd_tag = TAG_MID;
					end
				end
			endcase
			s_d.rd_pend = s_d.mem.req & ~s_d.mem.we;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign mem = s_q.mem;
	assign res = s_q.res;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	logic take;
	assign take = start && (s_q.st == ST_IDLE);

	sequence s_take_ret;
		take && cmd.op == OP_RET && !cmd.ram_fetch;
	endsequence
	sequence s_take_brk;
		take && cmd.op == OP_BRK && !cmd.ram_fetch;
	endsequence
	sequence s_take_interrupt_exit;
		take && cmd.op == OP_INTERRUPT_EXIT && !cmd.ram_fetch;
	endsequence

	a_ret_clocks: assert property (s_take_ret |-> ##1 res.busy [*7] ##1 res.done)
		else $error("exit did not finish in seven clocks");
	a_brk_clocks: assert property (s_take_brk |-> ##8 (res.done && res.pc[19:16] == 4'h0))
		else $error("break did not finish in seven clocks");
	a_ram_stretch: assert property (take && cmd.op == OP_RET && cmd.ram_fetch |-> ##35 res.done)
		else $error("RAM fetch count not 34");
	a_call_clocks: assert property (take && cmd.op == OP_CALL_ABS20 && !cmd.ram_fetch |-> ##5 res.done)
		else $error("long call not four clocks");
	a_push_top: assert property (take && cmd.op == OP_CALL_REL |=> mem.req && mem.we
		&& mem.addr[15:0] == $past(cmd.sp) - 16'h0002 && mem.wdata == {4'h0, s_q.ret[19:16]})
		else $error("first push not top byte at SP-2");
	a_brk_psw: assert property (s_take_brk |=> mem.we && mem.wdata == s_q.program_status_word
		&& mem.addr[15:0] == s_q.sp - 16'h0001)
		else $error("break did not save status word first");
	a_brk_ie: assert property (res.done && s_q.op == OP_BRK |-> !res.program_status_word[7]
		&& res.sp == s_q.sp - 16'h0004)
		else $error("break left interrupts enabled");
	a_tbl_read: assert property (take && cmd.op == OP_TBL |-> ##4 (mem.req && !mem.we
		&& mem.addr == {4'h0, s_q.tidx}) ##1 (mem.addr == {4'h0, s_q.tidx + 16'h0001}))
		else $error("table read order wrong");
	a_ret_flags: assert property (res.done && s_q.op == OP_RET |-> res.program_status_word == s_q.program_status_word
		&& res.sp == s_q.sp + 16'h0004)
		else $error("exit changed flags or SP");
	a_interrupt_exit_psw: assert property (take && cmd.op == OP_INTERRUPT_EXIT |-> ##4 (mem.req && !mem.we
		&& mem.addr[15:0] == s_q.sp + 16'h0003))
		else $error("status word not popped from SP+3");
	a_done_pulse: assert property (res.done |=> !res.done)
		else $error("done held longer than one clock");
	a_interrupt_exit_clocks: assert property (s_take_interrupt_exit |-> ##8 !res.done ##1 res.done)
		else $error("interrupt exit not eight clocks");
	a_tbl_clocks: assert property (take && cmd.op == OP_TBL && !cmd.ram_fetch |-> ##7 res.done)
		else $error("table call not six clocks");
	a_brk_vector: assert property (s_take_brk |-> ##5 (mem.req && !mem.we && mem.addr == VEC_LOW)
		##1 (mem.req && !mem.we && mem.addr == VEC_HIGH))
		else $error("break vector read order wrong");
endmodule : crs_seq

// *** rtl/crs_pkg.sv ***
// Operation
// - register call pushes PC+2, loads bank:pair
// - relative call pushes PC+3, adds displacement
// - short absolute call zero-fills upper bits
// - long absolute call loads 20-bit operand
// - table call reads vector from bank zero
// - break saves status word, then PC+2
// - break vector read from 7E and 7F
// - break lowers SP by four, clears enable
// - subroutine exit pops three bytes, flags kept
// - interrupt/break exit also pops status word
// - listed counts for RAM and register data
// - RAM fetch stretches count to 4N+6
package crs_pkg;
	localparam int AW = 20;
	localparam int SW = 16;
	localparam int CW = 6;
	typedef enum logic [3:0] {
		OP_CALL_REG = 4'h0,
		OP_CALL_REL = 4'h1,
		OP_CALL_ABS16 = 4'h2,
		OP_CALL_ABS20 = 4'h3,
		OP_TBL = 4'h4,
		OP_BRK = 4'h5,
		OP_RET = 4'h6,
		OP_INTERRUPT_EXIT = 4'h7,
		OP_BREAK_EXIT = 4'h8
	} crs_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1
	} crs_st_t;
	localparam logic [CW-1:0] CLK_CALL = 6'h04;
	localparam logic [CW-1:0] CLK_TBL = 6'h06;
	localparam logic [CW-1:0] CLK_BRK = 6'h07;
	localparam logic [CW-1:0] CLK_RET = 6'h07;
	localparam logic [CW-1:0] CLK_INTERRUPT_EXIT = 6'h08;
	localparam int RAM_SHIFT = 2;
	localparam logic [CW-1:0] RAM_ADD = 6'h06;
	localparam logic [AW-1:0] LEN_2 = 20'h00002;
	localparam logic [AW-1:0] LEN_3 = 20'h00003;
	localparam logic [AW-1:0] LEN_4 = 20'h00004;
	localparam logic [SW-1:0] OFS_PSW = 16'h0001;
	localparam logic [SW-1:0] OFS_TOP = 16'h0002;
	localparam logic [SW-1:0] POP_PSW = 16'h0003;
	localparam logic [SW-1:0] SP_ADJ = 16'h0004;
	localparam logic [SW-1:0] TBL_NEXT = 16'h0001;
	localparam logic [AW-1:0] VEC_LOW = 20'h0007E;
	localparam logic [AW-1:0] VEC_HIGH = 20'h0007F;
	localparam logic [3:0] LOW_BANK = 4'h0;
	localparam logic [3:0] STACK_BANK = 4'h0;
	localparam int IE_BIT = 7;
	localparam logic [1:0] TAG_LOW = 2'h0;
	localparam logic [1:0] TAG_MID = 2'h1;
	localparam logic [1:0] TAG_TOP = 2'h2;
	localparam logic [1:0] TAG_PSW = 2'h3;
	localparam logic [CW-1:0] STEP0 = 6'h00;
	localparam logic [CW-1:0] STEP1 = 6'h01;
	localparam logic [CW-1:0] STEP2 = 6'h02;
	localparam logic [CW-1:0] STEP3 = 6'h03;
	localparam logic [CW-1:0] STEP4 = 6'h04;
	localparam logic [CW-1:0] STEP5 = 6'h05;
	typedef struct packed {
		crs_op_t op;
		logic ram_fetch;
		logic [AW-1:0] pc;
		logic [SW-1:0] sp;
		logic [7:0] program_status_word;
		logic [3:0] bank;
		logic [SW-1:0] pair;
		logic [SW-1:0] rel;
		logic [SW-1:0] abs16;
		logic [AW-1:0] abs20;
		logic [SW-1:0] tidx;
	} crs_cmd_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [AW-1:0] addr;
		logic [7:0] wdata;
	} crs_mem_t;
	typedef struct packed {
		logic done;
		logic busy;
		logic [AW-1:0] pc;
		logic [SW-1:0] sp;
		logic [7:0] program_status_word;
	} crs_res_t;
	typedef struct packed {
		crs_st_t st;
		crs_op_t op;
		logic [CW-1:0] cnt;
		logic [CW-1:0] lim;
		logic [AW-1:0] ret;
		logic [AW-1:0] pc;
		logic [SW-1:0] sp;
		logic [7:0] program_status_word;
		logic [SW-1:0] tidx;
		logic rd_pend;
		logic [1:0] rd_tag;
		logic rd_due;
		logic [1:0] due_tag;
		crs_mem_t mem;
		crs_res_t res;
	} crs_state_t;
endpackage : crs_pkg

// *** rtl/crs_target.sv ***
`timescale 1ns/10ps
module crs_target import crs_pkg::*; (
	input crs_cmd_t cmd,
	output logic [AW-1:0] ret_addr,
	output logic [AW-1:0] target
);
	logic [AW-1:0] len;
	always_comb begin
		case (cmd.op)
			OP_CALL_REL, OP_CALL_ABS16: len = LEN_3;
			OP_CALL_ABS20: len = LEN_4;
			default: len = LEN_2;
		endcase
		ret_addr = cmd.pc + len;
		case (cmd.op)
			OP_CALL_REG: target = {cmd.bank, cmd.pair};
			OP_CALL_REL: target = ret_addr + {{(AW-SW){cmd.rel[SW-1]}}, cmd.rel};
			OP_CALL_ABS16: target = {LOW_BANK, cmd.abs16};
			OP_CALL_ABS20: target = cmd.abs20;
			// vector or popped bytes arrive later; top byte stays clear unless an exit pops it
			default: target = '0;
		endcase
	end
endmodule : crs_target

// *** verif/crs_mem_model.sv ***
`timescale 1ns/10ps
module crs_mem_model import crs_pkg::*; (
	input wire logic mclk,
	input crs_mem_t mem,
	output logic [7:0] mem_rdata
);
	logic [7:0] ram [0:(1<<AW)-1];
	initial mem_rdata = 8'h5A;
	// read data good for one cycle only, then it flips so stale use shows
	always @(posedge mclk) begin
		if (mem.req && mem.we) begin
			ram[mem.addr] <= mem.wdata;
		end
		if (mem.req && !mem.we) begin
			mem_rdata <= ram[mem.addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : crs_mem_model

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb import crs_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	crs_cmd_t cmd = '0;
	logic [7:0] mem_rdata;
	crs_mem_t mem;
	crs_res_t res;
	int miscompares = 0;
	int comparisons = 0;
	always #4 mclk = ~mclk;
	crs_seq crs_seq_i (.mclk(mclk), .rst(rst), .start(start), .cmd(cmd), .mem_rdata(mem_rdata),
		.mem(mem), .res(res));
	crs_mem_model crs_mem_model_i (.mclk(mclk), .mem(mem), .mem_rdata(mem_rdata));
	task chk(input string what, input logic [AW-1:0] e, input logic [AW-1:0] g);
		comparisons++;
		if (e !== g) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task close_out;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task set(input crs_op_t op, input logic [AW-1:0] pc, input logic [SW-1:0] sp);
		cmd = '0;
		cmd.op = op;
		cmd.pc = pc;
		cmd.sp = sp;
		cmd.program_status_word = 8'hC5;
	endtask : set
	// start held for hold cycles; extra requests fall while busy
	task run(input int hold, input logic [CW-1:0] n, input logic [AW-1:0] pc, input logic [SW-1:0] sp,
		input logic [7:0] program_status_word);
		int k;
		@(negedge mclk);
		start = 1'b1;
		repeat (hold) @(negedge mclk);
		start = 1'b0;
		k = hold - 1;
		while (res.done !== 1'b1 && k < 60) begin
			@(negedge mclk);
			k++;
		end
		chk("cycles", AW'(n), AW'(k));
		chk("pc", pc, res.pc);
		chk("sp", AW'(sp), AW'(res.sp));
		chk("psw", AW'(program_status_word), AW'(res.program_status_word));
		chk("busy", '0, AW'(res.busy));
	endtask : run
	task stk(input logic [SW-1:0] sp, input logic [AW-1:0] r);
		chk("top", AW'(r[19:16]), AW'(crs_mem_model_i.ram[{4'h0, sp - 16'h0002}]));
		chk("mid", AW'(r[15:8]), AW'(crs_mem_model_i.ram[{4'h0, sp - 16'h0003}]));
		chk("low", AW'(r[7:0]), AW'(crs_mem_model_i.ram[{4'h0, sp - 16'h0004}]));
	endtask : stk
	task t_reg;
		set(OP_CALL_REG, 20'h3FFFE, 16'hFF00);
		cmd.bank = 4'hA;
		cmd.pair = 16'h1234;
		run(1, CLK_CALL, 20'hA1234, 16'hFEFC, 8'hC5);
		stk(16'hFF00, 20'h40000);
		$display("reg call done");
	endtask : t_reg
	task t_rel;
		set(OP_CALL_REL, 20'h12345, 16'hF000);
		cmd.rel = 16'hFFF0;
		run(1, CLK_CALL, 20'h12338, 16'hEFFC, 8'hC5);
		stk(16'hF000, 20'h12348);
		$display("rel call done");
	endtask : t_rel
	task t_a16;
		set(OP_CALL_ABS16, 20'hF0000, 16'hE000);
		cmd.abs16 = 16'hBEEF;
		run(3, CLK_CALL, 20'h0BEEF, 16'hDFFC, 8'hC5);
		stk(16'hE000, 20'hF0003);
		$display("abs16 call done");
	endtask : t_a16
	task t_a20;
		set(OP_CALL_ABS20, 20'h00010, 16'hD000);
		cmd.abs20 = 20'hFEDCB;
		cmd.ram_fetch = 1'b1;
		run(1, 6'h16, 20'hFEDCB, 16'hCFFC, 8'hC5);
		stk(16'hD000, 20'h00014);
		$display("abs20 call done");
	endtask : t_a20
	task t_tbl;
		set(OP_TBL, 20'h54321, 16'hC000);
		cmd.tidx = 16'h0040;
		crs_mem_model_i.ram[20'h00040] = 8'h78;
		crs_mem_model_i.ram[20'h00041] = 8'h56;
		run(1, CLK_TBL, 20'h05678, 16'hBFFC, 8'hC5);
		stk(16'hC000, 20'h54323);
		$display("table call done");
	endtask : t_tbl
	task t_brk;
		set(OP_BRK, 20'h00100, 16'hB000);
		cmd.program_status_word = 8'hFF;
		crs_mem_model_i.ram[20'h0007E] = 8'h22;
		crs_mem_model_i.ram[20'h0007F] = 8'h11;
		run(1, CLK_BRK, 20'h01122, 16'hAFFC, 8'h7F);
		chk("saved psw", AW'(8'hFF), AW'(crs_mem_model_i.ram[20'h0AFFF]));
		stk(16'hB000, 20'h00102);
		$display("break done");
	endtask : t_brk
	task t_ret;
		set(OP_RET, 20'h00000, 16'hA000);
		crs_mem_model_i.ram[20'h0A000] = 8'h44;
		crs_mem_model_i.ram[20'h0A001] = 8'h33;
		crs_mem_model_i.ram[20'h0A002] = 8'hF2;
		run(1, CLK_RET, 20'h23344, 16'hA004, 8'hC5);
		$display("exit done");
	endtask : t_ret
	task t_rti;
		for (int i = 0; i < 2; i++) begin
			set(i ? OP_BREAK_EXIT : OP_INTERRUPT_EXIT, 20'h00000, 16'h9000);
			crs_mem_model_i.ram[20'h09000] = 8'h44;
			crs_mem_model_i.ram[20'h09001] = 8'h33;
			crs_mem_model_i.ram[20'h09002] = 8'h02;
			crs_mem_model_i.ram[20'h09003] = 8'hA5 + 8'(i);
			run(1, CLK_INTERRUPT_EXIT, 20'h23344, 16'h9004, 8'hA5 + 8'(i));
		end
		$display("irq and break exit done");
	endtask : t_rti
	initial begin
		#5000;
		miscompares++;
		$display("unexpected watchdog expected done seen hang");
		close_out;
	end
	initial begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		chk("idle", '0, AW'({res.done, res.busy}));
		t_reg;
		t_rel;
		t_a16;
		t_a20;
		t_tbl;
		t_brk;
		t_ret;
		t_rti;
		close_out;
	end
endmodule : tb
